// *** pkg/dac_cal_pkg.sv ***
// Package: constants, types and correction arithmetic for the DAC level calibration block
package dac_cal_pkg;
    // ----------------------------------------
    // Resolution and reset values
    // ----------------------------------------
    localparam int RES = 16;
    localparam logic [15:0] FULL_SCALE = 16'hFFFF;
    localparam logic [15:0] HALF_SCALE = 16'h8000;
    localparam logic [15:0] X1_RST = 16'h0000;
    localparam logic [15:0] OFFSET_DAC_RST = 16'h0000;
    localparam logic [15:0] THR_RST = 16'h0000;
    localparam logic [2:0] RANGE_RST = 3'h0;
    localparam logic GAIN20_RST = 1'b0;
    localparam int MAX_RANGES = 7;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam int AW = 9;
    localparam int SLOT_STRIDE = 16;
    localparam logic [4:0] SLOT_FORCE = 5'h00;
    localparam logic [4:0] SLOT_CLH = 5'h01;
    localparam logic [4:0] SLOT_CLL = 5'h02;
    localparam logic [4:0] SLOT_CPH0 = 5'h03;
    localparam logic [1:0] FLD_X1 = 2'h0;
    localparam logic [1:0] FLD_M = 2'h1;
    localparam logic [1:0] FLD_C = 2'h2;
    localparam logic [AW-1:0] ADDR_OFFSET_DAC = 9'h110;
    localparam logic [AW-1:0] ADDR_OPEN_THR = 9'h114;
    localparam logic [AW-1:0] ADDR_GND_THR = 9'h118;
    localparam logic [AW-1:0] ADDR_CTRL = 9'h11C;
    localparam logic [AW-1:0] ADDR_RB_FORCE = 9'h120;
    localparam logic [AW-1:0] ADDR_RB_COMP = 9'h124;
    localparam logic [AW-1:0] ADDR_RB_CLAMP = 9'h128;
    localparam int CTRL_RANGE_LSB = 0;
    localparam int CTRL_GAIN_BIT = 4;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] x1;
        logic [15:0] m;
        logic [15:0] c;
    } cal_set_t;

    typedef struct packed {
        logic [2:0] range;
        logic gain20;
    } ctrl_t;

    // Unsaturated x2 = x1*(m+1)/2^16 + c - 2^15, wide enough to never wrap
    function automatic logic signed [19:0] cal_sum(input cal_set_t s);
        logic [32:0] prod;
        prod = 33'(s.x1) * (33'(s.m) + 33'h1);
        cal_sum = $signed({3'h0, prod[32:RES]}) + $signed({4'h0, s.c})
            - $signed({4'h0, HALF_SCALE});
    endfunction

    // Clip to the converter's code range instead of wrapping
    function automatic logic [15:0] sat16(input logic signed [19:0] v);
        if (v < 0) begin
            sat16 = 16'h0000;
        end else if (v > $signed({4'h0, FULL_SCALE})) begin
            sat16 = FULL_SCALE;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // Byte-lane merge of the low 16 bits
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction
endpackage

// *** src/dac_level_calibration.sv ***
// Module: calibrated DAC level path with an Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Loaded code is x1 times gain plus one over 2^16, plus offset minus half.
// - Each calibrated level drives its DAC with the corrected code, never raw x1.
// - Software-written input word per level sits in a 16-bit input register.
// - Gain registers reset to all ones, giving exact unity gain.
// - Offset registers reset to half scale, contributing zero offset.
// - Force level has one correction set, used whatever the current range.
// - Comparators have seven correction sets; the active range picks one.
// - Each clamp level has its own correction set, shared across all ranges.
// - One 16-bit offset DAC code biases force, comparator and clamp levels.
// - Open-sense and ground-sense thresholds are not shifted by the offset code.
// - A 16-bit open-sense threshold sets allowed force-to-sense difference.
// - A 16-bit ground-sense threshold sets allowed load-ground difference.
// - Current measure amplifier gain selectable between 10 and 20.
// - Clamp current code is relative to midscale; 32768 means zero current.
module dac_level_calibration #(
    parameter int N_RANGES = 7 // Current ranges with own comparator sets
) (
    input wire logic core_clk, // 40 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic [dac_cal_pkg::AW-1:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte lanes
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait, low one cycle to answer
    output logic [15:0] force_code, // Corrected force level code
    output logic [15:0] clamp_hi_code, // Corrected clamp high code
    output logic [15:0] clamp_lo_code, // Corrected clamp low code
    output logic [15:0] comp_hi_code, // Corrected comparator high code
    output logic [15:0] comp_lo_code, // Corrected comparator low code
    output logic signed [15:0] clamp_hi_current, // Clamp high rel. to midscale
    output logic signed [15:0] clamp_lo_current, // Clamp low rel. to midscale
    output logic [15:0] offset_dac_code, // Shared offset DAC code
    output logic [15:0] open_sense_threshold, // Open-sense alarm level
    output logic [15:0] ground_sense_threshold, // Ground-sense alarm level
    output logic current_measure_gain // 1: gain 20, 0: gain 10
);
    import dac_cal_pkg::*;

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (N_RANGES < 1 || N_RANGES > MAX_RANGES) begin : g_bad_ranges
        $error("N_RANGES must be 1 to 7");
    end

    localparam int NSLOT = 3 + 2 * N_RANGES;
    localparam logic [4:0] SLOT_CPL0 = 5'(int'(SLOT_CPH0) + N_RANGES);
    localparam logic [AW-1:0] SLOT_END = AW'(NSLOT * SLOT_STRIDE);
    localparam logic [2:0] LAST_RANGE = 3'(N_RANGES - 1);

    // ----------------------------------------
    // State
    // ----------------------------------------
    cal_set_t set_r [NSLOT];
    logic [15:0] offset_dac_r;
    logic [15:0] open_thr_r;
    logic [15:0] gnd_thr_r;
    ctrl_t ctrl_r;
    logic wait_r;
    logic [31:0] rdata_r;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Answer comes one cycle after the request is seen
    wire logic req_seen = (read | write) & wait_r;
    wire logic wr_go = write & ~wait_r;
    wire logic [4:0] slot_w = address[8:4];
    wire logic [1:0] fld_w = address[3:2];
    wire logic in_slot = (address < SLOT_END) && (fld_w != 2'h3);
    wire logic hit_offset = address == ADDR_OFFSET_DAC;
    wire logic hit_open = address == ADDR_OPEN_THR;
    wire logic hit_gnd = address == ADDR_GND_THR;
    wire logic hit_ctrl = address == ADDR_CTRL;

    // Comparator set follows the active range; voltage-sense range reuses the last
    wire logic [2:0] comp_idx = (ctrl_r.range > LAST_RANGE) ? LAST_RANGE : ctrl_r.range;
    wire logic [4:0] cph_slot = SLOT_CPH0 + 5'(comp_idx);
    wire logic [4:0] cpl_slot = SLOT_CPL0 + 5'(comp_idx);

    // Slot field readback
    wire cal_set_t rd_set = in_slot ? set_r[slot_w] : '0;
    wire logic [15:0] rd_fld = (fld_w == FLD_X1) ? rd_set.x1 :
                               (fld_w == FLD_M) ? rd_set.m : rd_set.c;
    wire logic [31:0] rd_w =
        in_slot ? {16'h0000, rd_fld} :
        hit_offset ? {16'h0000, offset_dac_r} :
        hit_open ? {16'h0000, open_thr_r} :
        hit_gnd ? {16'h0000, gnd_thr_r} :
        hit_ctrl ? {27'h0, ctrl_r.gain20, 1'b0, ctrl_r.range} :
        (address == ADDR_RB_FORCE) ? {16'h0000, force_code} :
        (address == ADDR_RB_COMP) ? {comp_hi_code, comp_lo_code} :
        (address == ADDR_RB_CLAMP) ? {clamp_hi_code, clamp_lo_code} :
        32'h0000_0000;

    // ----------------------------------------
    // Correction arithmetic
    // ----------------------------------------
    // Five engines in parallel so every level is refreshed each cycle
    wire logic signed [19:0] raw_force = cal_sum(set_r[SLOT_FORCE]);
    wire logic signed [19:0] raw_clh = cal_sum(set_r[SLOT_CLH]);
    wire logic signed [19:0] raw_cll = cal_sum(set_r[SLOT_CLL]);
    wire logic signed [19:0] raw_cph = cal_sum(set_r[cph_slot]);
    wire logic signed [19:0] raw_cpl = cal_sum(set_r[cpl_slot]);
    wire logic [15:0] clh_w = sat16(raw_clh);
    wire logic [15:0] cll_w = sat16(raw_cll);

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // Waitrequest idles high and drops for exactly the answering cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= ~req_seen;
            if (req_seen) begin
                rdata_r <= rd_w;
            end
        end
    end

    // ----------------------------------------
    // Correction register file
    // ----------------------------------------
    // Unmapped writes fall through silently
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NSLOT; i++) begin
                set_r[i].x1 <= X1_RST;
                set_r[i].m <= FULL_SCALE;
                set_r[i].c <= HALF_SCALE;
            end
        end else if (wr_go && in_slot) begin
            case (fld_w)
                FLD_X1: set_r[slot_w].x1 <= merge16(set_r[slot_w].x1, writedata,
                                                    byteenable);
                FLD_M: set_r[slot_w].m <= merge16(set_r[slot_w].m, writedata, byteenable);
                FLD_C: set_r[slot_w].c <= merge16(set_r[slot_w].c, writedata, byteenable);
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Shared levels and control
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            offset_dac_r <= OFFSET_DAC_RST;
            open_thr_r <= THR_RST;
            gnd_thr_r <= THR_RST;
            ctrl_r <= '{range: RANGE_RST, gain20: GAIN20_RST};
        end else if (wr_go) begin
            if (hit_offset) begin
                offset_dac_r <= merge16(offset_dac_r, writedata, byteenable);
            end
            if (hit_open) begin
                open_thr_r <= merge16(open_thr_r, writedata, byteenable);
            end
            if (hit_gnd) begin
                gnd_thr_r <= merge16(gnd_thr_r, writedata, byteenable);
            end
            if (hit_ctrl && byteenable[0]) begin
                ctrl_r.range <= writedata[CTRL_RANGE_LSB +: 3];
                ctrl_r.gain20 <= writedata[CTRL_GAIN_BIT];
            end
        end
    end

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    // Force, clamp and comparator DACs see only the corrected, clipped code
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            force_code <= 16'h0000;
            clamp_hi_code <= 16'h0000;
            clamp_lo_code <= 16'h0000;
            comp_hi_code <= 16'h0000;
            comp_lo_code <= 16'h0000;
            clamp_hi_current <= 16'sh0000;
            clamp_lo_current <= 16'sh0000;
        end else begin
            force_code <= sat16(raw_force);
            clamp_hi_code <= clh_w;
            clamp_lo_code <= cll_w;
            comp_hi_code <= sat16(raw_cph);
            comp_lo_code <= sat16(raw_cpl);
            clamp_hi_current <= $signed(clh_w ^ HALF_SCALE);
            clamp_lo_current <= $signed(cll_w ^ HALF_SCALE);
        end
    end

    // Offset and thresholds leave straight from their registers
    assign offset_dac_code = offset_dac_r;
    assign open_sense_threshold = open_thr_r;
    assign ground_sense_threshold = gnd_thr_r;
    assign current_measure_gain = ctrl_r.gain20;
    assign waitrequest = wait_r;
    assign readdata = rdata_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_unity_gain: assert property (
        ($past(set_r[SLOT_FORCE].m) == FULL_SCALE && $past(set_r[SLOT_FORCE].c) == HALF_SCALE)
        |-> force_code == $past(set_r[SLOT_FORCE].x1))
        else $error("force code differs from x1 at unity gain");

    a_sat_high: assert property (
        $past(raw_force) > $signed({4'h0, FULL_SCALE}) |-> force_code == FULL_SCALE)
        else $error("force code wrapped above full scale");

    a_sat_low: assert property (
        $past(raw_cph) < 0 |-> comp_hi_code == 16'h0000)
        else $error("comparator code wrapped below zero");

    a_force_range_free: assert property (
        ($changed(ctrl_r.range) && !wr_go) ##1 !wr_go |-> $stable(force_code))
        else $error("force code moved with range change");

    a_clamp_shared: assert property (
        ($changed(ctrl_r.range) && !wr_go) ##1 !wr_go
        |-> $stable(clamp_hi_code) && $stable(clamp_lo_code))
        else $error("clamp code moved with range change");

    a_comp_follow: assert property (
        ##1 comp_hi_code == sat16(cal_sum(set_r[SLOT_CPH0 + 5'($past(comp_idx))]))
            || $past(wr_go))
        else $error("comparator set does not follow range");

    a_clamp_mid: assert property (
        clamp_hi_code == HALF_SCALE |-> clamp_hi_current == 16'sh0000)
        else $error("midscale clamp code not zero current");

    a_offset_load: assert property (
        (wr_go && hit_offset && byteenable[1:0] == 2'h3)
        |=> offset_dac_code == $past(writedata[15:0]) && $stable(open_sense_threshold)
            && $stable(ground_sense_threshold))
        else $error("offset write lost or leaked into thresholds");

    a_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("waitrequest did not drop for one cycle");

    a_gain_select: assert property (
        (wr_go && hit_ctrl && byteenable[0])
        |=> current_measure_gain == $past(writedata[CTRL_GAIN_BIT]))
        else $error("measure gain select not applied");

    a_comp_lo_follow: assert property (
        ##1 comp_lo_code == sat16(cal_sum(set_r[SLOT_CPL0 + 5'($past(comp_idx))]))
            || $past(wr_go))
        else $error("comparator low set does not follow range");

    // Reset leaves codes and currents both at zero, so skip the edge after it
    a_clamp_current: assert property (
        !$past(rst) |-> clamp_hi_current == $signed(clamp_hi_code - HALF_SCALE)
            && clamp_lo_current == $signed(clamp_lo_code - HALF_SCALE))
        else $error("clamp current not code minus midscale");

    a_open_lane_lo: assert property (
        (wr_go && hit_open) |=> open_sense_threshold[7:0] == ($past(byteenable[0]) ?
            $past(writedata[7:0]) : $past(open_sense_threshold[7:0])))
        else $error("open-sense low byte not merged");

    a_open_lane_hi: assert property (
        (wr_go && hit_open) |=> open_sense_threshold[15:8] == ($past(byteenable[1]) ?
            $past(writedata[15:8]) : $past(open_sense_threshold[15:8])))
        else $error("open-sense high byte not merged");

    a_gnd_load: assert property (
        (wr_go && hit_gnd && byteenable[1:0] == 2'h3)
        |=> ground_sense_threshold == $past(writedata[15:0]))
        else $error("ground-sense write not applied");

    a_x1_load: assert property (
        (wr_go && in_slot && fld_w == FLD_X1 && byteenable[1:0] == 2'h3)
        |=> set_r[$past(slot_w)].x1 == $past(writedata[15:0]))
        else $error("input word write not held");

    a_rb_force: assert property (
        (read && waitrequest && address == ADDR_RB_FORCE)
        |=> readdata == {16'h0000, $past(force_code)})
        else $error("force readback not the applied code");

    a_rb_comp: assert property (
        (read && waitrequest && address == ADDR_RB_COMP)
        |=> readdata == {$past(comp_hi_code), $past(comp_lo_code)})
        else $error("comparator readback not the applied codes");

    a_field_gap: assert property (
        (read && waitrequest && address < SLOT_END && fld_w == 2'h3)
        |=> readdata == 32'h0000_0000)
        else $error("unmapped slot field read not zero");

    a_wait_idle: assert property (
        (!read && !write && waitrequest) |=> waitrequest)
        else $error("waitrequest dropped with no request");
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench: bus-driven checks of the calibrated DAC level path
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import dac_cal_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [AW-1:0] address = 9'h000;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [15:0] force_code, clamp_hi_code, clamp_lo_code, comp_hi_code, comp_lo_code;
    logic signed [15:0] clamp_hi_current, clamp_lo_current;
    logic [15:0] offset_dac_code, open_sense_threshold, ground_sense_threshold;
    logic current_measure_gain;
    logic [31:0] rdata;
    int failures = 0;
    int cmp_count = 0;

    dac_level_calibration #(.N_RANGES(7)) u_dut (.core_clk(core_clk), .rst(rst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .force_code(force_code), .clamp_hi_code(clamp_hi_code),
        .clamp_lo_code(clamp_lo_code), .comp_hi_code(comp_hi_code),
        .comp_lo_code(comp_lo_code), .clamp_hi_current(clamp_hi_current),
        .clamp_lo_current(clamp_lo_current), .offset_dac_code(offset_dac_code),
        .open_sense_threshold(open_sense_threshold),
        .ground_sense_threshold(ground_sense_threshold),
        .current_measure_gain(current_measure_gain));

    // ----------------------------------------
    // Clock, checks and bus tasks
    // ----------------------------------------
    always #12.5 core_clk = ~core_clk;

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask

    // One Avalon transfer; request held until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [8:0] a, input logic [15:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {16'h0000, d};
        byteenable <= be;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            $display("[FAIL] waitrequest expected 0 seen %b", waitrequest);
            failures++;
        end
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr16(input logic [8:0] a, input logic [15:0] d);
        acc(1'b1, a, d, 4'h3);
    endtask

    task automatic rd(input logic [8:0] a);
        acc(1'b0, a, 16'h0000, 4'hF);
    endtask

    // Codes follow a register write one edge later; three edges is ample
    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    function automatic logic [8:0] ra(input int s, input int f);
        ra = 9'(SLOT_STRIDE * s + 4 * f);
    endfunction

    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #(25 * 20000);
        failures++;
        tally_and_finish;
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        logic [15:0] eh;
        int k;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("force_code", 16'h0000, force_code);
        chk("clamp_hi_current", 16'h8000, clamp_hi_current);
        rd(ra(0, 1));
        chk("force m", FULL_SCALE, rdata[15:0]);
        rd(ra(12, 2));
        chk("comp c", HALF_SCALE, rdata[15:0]);
        // Unity path, then gain and offset terms
        wr16(ra(0, 0), 16'h1234);
        rd(ra(0, 0));
        chk("force x1", 16'h1234, rdata[15:0]);
        settle;
        chk("force_code", 16'h1234, force_code);
        wr16(ra(0, 1), 16'h3FFF);
        wr16(ra(0, 2), 16'h8010);
        wr16(ra(0, 0), 16'hFFFF);
        settle;
        chk("force_code", 16'h400F, force_code);
        rd(ADDR_RB_FORCE);
        chk("force readback", 16'h400F, rdata[15:0]);
        // Clipping at both ends instead of wrap
        wr16(ra(0, 1), 16'hFFFF);
        wr16(ra(0, 2), 16'hFFFF);
        settle;
        chk("force_code", 16'hFFFF, force_code);
        wr16(ra(0, 2), 16'h0000);
        wr16(ra(0, 0), 16'h1000);
        settle;
        chk("force_code", 16'h0000, force_code);
        wr16(ra(0, 2), 16'h8000);
        wr16(ra(0, 0), 16'h2345);
        // Distinct comparator sets; range 7 falls back to the last one
        for (k = 0; k < MAX_RANGES; k++) begin
            wr16(ra(3 + k, 0), 16'h1100 + 16'(k));
            wr16(ra(10 + k, 0), 16'h2200 + 16'(k));
        end
        wr16(ra(9, 2), 16'h8100);
        wr16(ra(1, 0), 16'h9000);
        wr16(ra(2, 0), 16'h7000);
        for (k = 0; k < 8; k++) begin
            wr16(ADDR_CTRL, 16'(k));
            settle;
            eh = 16'h1100 + 16'((k > 6) ? 6 : k) + ((k >= 6) ? 16'h0100 : 16'h0000);
            chk("comp_hi_code", eh, comp_hi_code);
            chk("comp_lo_code", 16'h2200 + 16'((k > 6) ? 6 : k), comp_lo_code);
            chk("force_code", 16'h2345, force_code);
            chk("clamp_hi_code", 16'h9000, clamp_hi_code);
            chk("clamp_lo_current", 16'hF000, clamp_lo_current);
        end
        chk("clamp_hi_current", 16'h1000, clamp_hi_current);
        rd(ADDR_RB_COMP);
        chk("comp readback hi", 16'h1206, rdata[31:16]);
        chk("comp readback lo", 16'h2206, rdata[15:0]);
        // Shared offset code and thresholds, open-sense one byte lane at a time
        wr16(ADDR_OFFSET_DAC, 16'hE000);
        acc(1'b1, ADDR_OPEN_THR, 16'hA5C3, 4'h1);
        wr16(ADDR_GND_THR, 16'h4321);
        settle;
        chk("offset_dac_code", 16'hE000, offset_dac_code);
        chk("force_code", 16'h2345, force_code);
        chk("open_sense_threshold", 16'h00C3, open_sense_threshold);
        chk("ground_sense_threshold", 16'h4321, ground_sense_threshold);
        acc(1'b1, ADDR_OPEN_THR, 16'hA5C3, 4'h2);
        settle;
        chk("open_sense_threshold", 16'hA5C3, open_sense_threshold);
        // Measure gain select, both settings
        wr16(ADDR_CTRL, 16'h0010);
        settle;
        chk("current_measure_gain", 16'h0001, {15'h0000, current_measure_gain});
        wr16(ADDR_CTRL, 16'h0000);
        settle;
        chk("current_measure_gain", 16'h0000, {15'h0000, current_measure_gain});
        // Comparator clipped below zero, clamp high at midscale
        wr16(ra(3, 2), 16'h0000);
        wr16(ra(1, 0), 16'h8000);
        settle;
        chk("comp_hi_code", 16'h0000, comp_hi_code);
        chk("clamp_hi_current", 16'h0000, clamp_hi_current);
        chk("clamp_lo_code", 16'h7000, clamp_lo_code);
        rd(ADDR_RB_CLAMP);
        chk("clamp readback hi", 16'h8000, rdata[31:16]);
        chk("clamp readback lo", 16'h7000, rdata[15:0]);
        // Read-only readback, unmapped places
        wr16(ADDR_RB_FORCE, 16'h0BAD);
        wr16(9'h1FC, 16'h5A5A);
        rd(ADDR_RB_FORCE);
        chk("force readback", 16'h2345, rdata[15:0]);
        rd(9'h1FC);
        chk("unmapped hi", 16'h0000, rdata[31:16]);
        chk("unmapped lo", 16'h0000, rdata[15:0]);
        rd(ra(0, 3));
        chk("field 3", 16'h0000, rdata[15:0]);
        // Second reset in mid-run restores calibration defaults
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(ra(0, 1));
        chk("force m", FULL_SCALE, rdata[15:0]);
        rd(ra(1, 2));
        chk("clamp c", HALF_SCALE, rdata[15:0]);
        tally_and_finish;
    end
endmodule

`default_nettype wire
